// file: design/uvz_alarm_decision.sv
// UV zone alarm decision: rate threshold, delay, voting, latching, fault
`timescale 1ns/1ns
`default_nettype none
`include "uvz_cfg.svh"
module uvz_alarm_decision #(
  parameter int unsigned QTR_CYCLES = `UVZ_QTR_NS / `UVZ_CLK_NS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire uvz_pkg::uvz_switch_s sw_pins,
  input wire logic [7:0] tube_pulse,
  input wire logic [3:0] det_present,
  input wire logic keylock_reset,
  input wire logic ext_inhibit,
  output logic [3:0] zone_fire,
  output logic fire_vote_a,
  output logic fire_vote_b,
  output logic [3:0] surv_alarm,
  output logic low_alarm,
  output uvz_pkg::uvz_fault_s fault,
  output logic [3:0] optical_integrity_test,
  output logic master_role
);
  import uvz_pkg::*;

  localparam int QW = $clog2(QTR_CYCLES + 1);

  function automatic logic [2:0] uvz_pop4(input logic [3:0] v);
    uvz_pop4 = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction

  // ==========================================================
  // Reset release and input synchronisers
  logic [1:0] rst_ff;
  logic rst_sn;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_sn = rst_ff[1];

  uvz_switch_s sw_m, sw_s;
  logic [5:0] pin_m, pin_s;
  logic [7:0] pul_m, pul_s, pul_d;
  always_ff @(posedge ref_clk or negedge rst_sn) begin
    if (!rst_sn) begin
      sw_m <= '0;
      sw_s <= '0;
      pin_m <= 6'h0;
      pin_s <= 6'h0;
      pul_m <= 8'h0;
      pul_s <= 8'h0;
      pul_d <= 8'h0;
    end else begin
      sw_m <= sw_pins;
      sw_s <= sw_m;
      pin_m <= {keylock_reset, ext_inhibit, det_present};
      pin_s <= pin_m;
      pul_m <= tube_pulse;
      pul_s <= pul_m;
      pul_d <= pul_s;
    end
  end

  logic clr;
  logic [3:0] present;
  logic [7:0] pedge;
  assign clr = pin_s[5] | pin_s[4];
  assign present = pin_s[3:0];
  assign pedge = pul_s & ~pul_d;

  // ==========================================================
  // Quarter-second measuring window
  logic [QW-1:0] qcnt;
  logic qtick;
  always_ff @(posedge ref_clk or negedge rst_sn) begin
    if (!rst_sn) begin
      qcnt <= '0;
      qtick <= 1'b0;
    end else begin
      qtick <= (qcnt == QW'(QTR_CYCLES - 1));
      if (qcnt == QW'(QTR_CYCLES - 1)) begin
        qcnt <= '0;
      end else begin
        qcnt <= qcnt + QW'(1);
      end
    end
  end

  // ==========================================================
  // Threshold and delay from the rockers
  uvz_cps_t thr;
  logic [5:0] dly_q;
  logic [2:0] req;
  always_comb begin
    if (sw_s.sens_closed == 4'h0) begin
      thr = 8'(`UVZ_SENS_MIN);
    end else begin
      thr = 8'(sw_s.sens_closed) * 8'(`UVZ_SENS_STEP);
    end
  end
  // Quarter-second units: weights 1,2,4,8,16 plus two
  assign dly_q = 6'(sw_s.delay_closed) + 6'(`UVZ_DLY_BASE_Q);
  // Odd codes count closed rockers rather than being rejected
  assign req = 3'h1 + 3'(sw_s.vote_closed[0]) + 3'(sw_s.vote_closed[1])
             + 3'(sw_s.vote_closed[2]);

  // ==========================================================
  // Per-channel rate and confirmation; 0-3 fire, 4-7 surveillance
  logic [7:0] cnt [8];
  logic [5:0] run [8];
  logic [7:0] above, half, live, low;
  logic [5:0] next_run [8];
  for (genvar i = 0; i < 8; i++) begin : g_chan
    // Rate over one window, scaled to cps by four
    assign above[i] = {cnt[i], 2'h0} >= {2'h0, thr};
    assign half[i] = {cnt[i], 3'h0} > {3'h0, thr};
    assign next_run[i] = !above[i] ? 6'h0 :
                         (run[i] == 6'h3F) ? run[i] : run[i] + 6'h1;
    always_ff @(posedge ref_clk or negedge rst_sn) begin
      if (!rst_sn) begin
        cnt[i] <= 8'h0;
        run[i] <= 6'h0;
        live[i] <= 1'b0;
        low[i] <= 1'b0;
      end else if (qtick) begin
        cnt[i] <= pedge[i] ? 8'h1 : 8'h0;
        run[i] <= next_run[i];
        live[i] <= next_run[i] >= dly_q;
        low[i] <= half[i];
      end else if (pedge[i] && cnt[i] != 8'hFF) begin
        cnt[i] <= cnt[i] + 8'h1;
      end
    end
  end

  // ==========================================================
  // Voting and latching
  logic latch;
  logic [3:0] seen, next_seen;
  logic vote_now, vote_hold, next_vote;
  assign latch = !sw_s.nonlatch_closed;
  assign vote_now = uvz_pop4(live[3:0]) >= req;
  // A fresh alarm wins over a clear in the same cycle
  assign next_seen = (clr ? 4'h0 : seen) | live[3:0];
  assign next_vote = (clr ? 1'b0 : vote_hold)
                   | (uvz_pop4(next_seen) >= req);

  always_ff @(posedge ref_clk or negedge rst_sn) begin
    if (!rst_sn) begin
      seen <= 4'h0;
      vote_hold <= 1'b0;
    end else if (latch) begin
      seen <= next_seen;
      vote_hold <= next_vote;
    end else begin
      // Track live zones so a switch to latching keeps what is on
      seen <= live[3:0];
      vote_hold <= vote_now;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sn) begin
    if (!rst_sn) begin
      zone_fire <= 4'h0;
      fire_vote_a <= 1'b0;
      fire_vote_b <= 1'b0;
    end else if (latch) begin
      zone_fire <= next_seen;
      fire_vote_a <= next_vote;
      fire_vote_b <= next_vote;
    end else begin
      zone_fire <= live[3:0];
      fire_vote_a <= vote_now;
      fire_vote_b <= vote_now;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sn) begin
    if (!rst_sn) begin
      surv_alarm <= 4'h0;
      low_alarm <= 1'b0;
    end else begin
      surv_alarm <= live[7:4];
      low_alarm <= |low[3:0];
    end
  end

  // ==========================================================
  // Detector supervision and role
  logic [3:0] enabled, missing;
  assign enabled = ~sw_s.zone_closed;
  assign missing = enabled & ~present;
  always_ff @(posedge ref_clk or negedge rst_sn) begin
    if (!rst_sn) begin
      fault <= '0;
      optical_integrity_test <= 4'h0;
      master_role <= 1'b0;
    end else begin
      fault.active <= |missing;
      fault.code <= (|missing) ? `UVZ_FAULT_NO_DET : `UVZ_FAULT_NONE;
      fault.zone <= missing;
      optical_integrity_test <= enabled & present;
      master_role <= sw_s.master_closed;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sn);

  a_thr_floor: assert property (thr >= 8'h08 && thr <= 8'h78)
    else $error("threshold outside 8..120 cps");
  a_thr_sum: assert property (sw_s.sens_closed != 4'h0 |->
      thr == {1'b0, sw_s.sens_closed, 3'h0})
    else $error("threshold not sum of weights");
  a_thr_empty: assert property (sw_s.sens_closed == 4'h0 |->
      thr == 8'h08)
    else $error("empty sensitivity not 8 cps");
  a_dly_sum: assert property (1'b1 |->
      dly_q == {1'b0, sw_s.delay_closed} + 6'h02)
    else $error("delay not closed sum plus half second");
  a_dly_conf: assert property (live[0] |-> run[0] >= dly_q)
    else $error("zone fire before confirmation delay");
  a_run_restart: assert property (qtick && !above[0] |=>
      run[0] == 6'h00 && !live[0])
    else $error("confirmation timing not restarted");
  a_fault_two: assert property (|missing |=>
      fault.active && fault.code == 4'h2)
    else $error("missing detector not flagged");
  a_fault_zone: assert property (1'b1 |=>
      fault.zone == $past(missing))
    else $error("fault zone bits wrong");
  a_fault_clean: assert property (missing == 4'h0 |=>
      !fault.active && fault.code == 4'h0)
    else $error("fault shown with all detectors present");
  a_closed_quiet: assert property (sw_s.zone_closed[0] |=>
      !optical_integrity_test[0] && !fault.zone[0])
    else $error("disabled zone tested or flagged");
  a_test_set: assert property (1'b1 |=>
      optical_integrity_test == $past(enabled & present))
    else $error("self-test set wrong");
  a_vote_pair: assert property (fire_vote_a == fire_vote_b)
    else $error("vote outputs differ");
  a_vote_none: assert property (sw_s.vote_closed == 3'h0 |->
      req == 3'h1)
    else $error("open voting rockers not one zone");
  a_vote_all: assert property (sw_s.vote_closed == 3'h7 |->
      req == 3'h4)
    else $error("closed voting rockers not four zones");
  a_nonlatch_vote: assert property (!latch && $past(!latch) |->
      fire_vote_a == $past(vote_now))
    else $error("non-latching vote wrong");
  a_nonlatch_zone: assert property (!latch && $past(!latch) |->
      zone_fire == $past(live[3:0]))
    else $error("non-latching zone output wrong");
  a_latch_hold: assert property (latch && fire_vote_a && !clr
      ##1 latch |-> fire_vote_a)
    else $error("latched vote dropped");
  a_latch_zone: assert property ($past(latch) && !$past(clr) |->
      (zone_fire & $past(zone_fire)) == $past(zone_fire))
    else $error("latched zone dropped");
  a_clear_latch: assert property (latch && clr && live[3:0] == 4'h0
      |=> zone_fire == 4'h0 && !fire_vote_a)
    else $error("clear did not de-latch");
  a_surv_free: assert property (live[7:4] == 4'h0 |=>
      surv_alarm == 4'h0)
    else $error("surveillance zone latched");
  a_surv_follow: assert property (1'b1 |=>
      surv_alarm == $past(live[7:4]))
    else $error("surveillance output not live");
  a_role_sel: assert property (sw_s.master_closed |=> master_role)
    else $error("master role not selected");
  a_role_slave: assert property (!sw_s.master_closed |=>
      !master_role)
    else $error("slave role not selected");
  a_low_alarm: assert property (qtick && |half[3:0] ##1 1'b1
      |=> low_alarm)
    else $error("low alarm missing");
  a_low_quiet: assert property (qtick && half[3:0] == 4'h0 ##1 1'b1
      |=> !low_alarm)
    else $error("low alarm without half rate");

  c_vote_rise: cover property ($rose(fire_vote_a));
  c_fault_seen: cover property ($rose(fault.active));
  c_surv_alarm: cover property ($rose(|surv_alarm));
  c_delatch: cover property (latch && fire_vote_a ##1 clr ##1 !fire_vote_a);
endmodule
`default_nettype wire

// file: design/uvz_cfg.svh
// Configuration constants for the UV zone alarm decision block
`ifndef UVZ_CFG_SVH
`define UVZ_CFG_SVH
`define UVZ_CLK_NS 20
`define UVZ_QTR_NS 250000000
`define UVZ_SENS_STEP 8
`define UVZ_SENS_MIN 8
`define UVZ_DLY_BASE_Q 2
`define UVZ_FAULT_NO_DET 4'h2
`define UVZ_FAULT_NONE 4'h0
`endif

// file: design/uvz_pkg.sv
// Types shared by the UV zone alarm decision block
`default_nettype none
package uvz_pkg;
  // Switch pins, each bit high while its rocker is closed
  typedef struct packed {
    logic [3:0] zone_closed;
    logic [3:0] sens_closed;
    logic [2:0] vote_closed;
    logic master_closed;
    logic nonlatch_closed;
    logic [4:0] delay_closed;
  } uvz_switch_s;
  typedef struct packed {
    logic active;
    logic [3:0] code;
    logic [3:0] zone;
  } uvz_fault_s;
  typedef logic [7:0] uvz_cps_t;
endpackage
`default_nettype wire

// file: dv/uvz_tube_model.sv
// Pulse source standing in for the UV sensor tubes of all eight zones
`timescale 1ns/1ns
`default_nettype none
module uvz_tube_model (
  input wire logic ref_clk,
  input wire logic [7:0] on_mask,
  input wire logic [7:0] period,
  output logic [7:0] tube_pulse
);
  logic [7:0] cnt = 8'h00;
  logic [7:0] act = 8'h00;
  // Mask taken in the first pulse cycle, so a one-cycle runt pulse can appear
  always_ff @(posedge ref_clk) begin
    cnt <= (cnt + 8'h01 >= period) ? 8'h00 : cnt + 8'h01;
    if (cnt == 8'h00) begin
      act <= on_mask;
    end
  end
  // Two cycles high, the rest low; idle tubes stay low
  assign tube_pulse = (cnt < 8'h02) ? act : 8'h00;
endmodule
`default_nettype wire

// file: dv/test_uv_zone_alarm_decision.sv
// Self-checking bench for the UV zone alarm decision block
`timescale 1ns/1ns
`default_nettype none
module test_uv_zone_alarm_decision;
  import uvz_pkg::*;
  localparam int QTR = 160;
  typedef struct packed {
    logic [3:0] sens; logic [7:0] per; logic fire; logic low;
  } uvz_row_s;
  // Rates sit well clear of each threshold edge: window phase drifts
  uvz_row_s rows [8] = '{
    '{4'h0, 8'h10, 1'b1, 1'b1}, '{4'h1, 8'h10, 1'b1, 1'b1},
    '{4'h3, 8'h10, 1'b1, 1'b1}, '{4'h6, 8'h10, 1'b0, 1'b1},
    '{4'h8, 8'h10, 1'b0, 1'b1}, '{4'hF, 8'h10, 1'b0, 1'b0},
    '{4'hF, 8'h08, 1'b0, 1'b1}, '{4'hF, 8'h04, 1'b1, 1'b1}};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  uvz_switch_s sw = 18'h00020;
  logic [7:0] on_mask = 8'h00;
  logic [7:0] period = 8'h10;
  logic [3:0] det_present = 4'hF;
  logic keylock_reset = 1'b0;
  logic ext_inhibit = 1'b0;
  logic [7:0] tube_pulse;
  logic [3:0] zone_fire, surv_alarm, oit;
  logic fire_vote_a, fire_vote_b, low_alarm, master_role;
  uvz_fault_s fault;
  int n_fail = 0;
  int checks = 0;
  always #10 ref_clk = ~ref_clk;
  uvz_tube_model tubes (.ref_clk(ref_clk), .on_mask(on_mask),
    .period(period), .tube_pulse(tube_pulse));
  uvz_alarm_decision #(.QTR_CYCLES(QTR)) dut (.ref_clk(ref_clk),
    .rst_n(rst_n), .sw_pins(sw), .tube_pulse(tube_pulse),
    .det_present(det_present), .keylock_reset(keylock_reset),
    .ext_inhibit(ext_inhibit), .zone_fire(zone_fire),
    .fire_vote_a(fire_vote_a), .fire_vote_b(fire_vote_b),
    .surv_alarm(surv_alarm), .low_alarm(low_alarm), .fault(fault),
    .optical_integrity_test(oit), .master_role(master_role));
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic win(input int n);
    step(n * QTR);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    step(9);
    chk(16'({zone_fire, fire_vote_a, low_alarm, master_role}), 16'h0);
    step(1);
    rst_n = 1'b1;
    step(4);
    sw.master_closed = 1'b1;
    step(4);
    chk(16'(master_role), 16'h1);
    sw.master_closed = 1'b0;
    sw.zone_closed = 4'h0;
    det_present = 4'hB;
    step(4);
    chk(16'(master_role), 16'h0);
    chk(16'(fault), 16'({1'b1, 4'h2, 4'h4}));
    chk(16'(oit), 16'hB);
    sw.zone_closed = 4'h1;
    det_present = 4'hF;
    step(4);
    chk(16'(fault), 16'h0);
    chk(16'(oit), 16'hE);
    // Shortest delay kept off the 8 cps rows: false actuation risk
    sw.delay_closed = 5'h01;
    foreach (rows[i]) begin
      sw.sens_closed = rows[i].sens;
      period = rows[i].per;
      on_mask = 8'h0F;
      win(6);
      chk(16'(zone_fire), 16'({4{rows[i].fire}}));
      chk(16'(low_alarm), 16'(rows[i].low));
      chk(16'(fire_vote_a), 16'(rows[i].fire));
      on_mask = 8'h00;
      win(4);
      chk(16'(zone_fire), 16'h0);
    end
    sw.sens_closed = 4'h0;
    period = 8'h10;
    for (int n = 1; n <= 4; n++) begin
      sw.vote_closed = 3'(3'h7 >> (4 - n));
      on_mask = 8'(4'hF >> (5 - n));
      win(6);
      chk(16'({fire_vote_a, fire_vote_b}), 16'h0);
      on_mask = 8'(4'hF >> (4 - n));
      win(6);
      chk(16'({fire_vote_a, fire_vote_b}), 16'h3);
      on_mask = 8'h00;
      win(4);
    end
    sw.nonlatch_closed = 1'b0;
    sw.vote_closed = 3'h1;
    on_mask = 8'h01;
    win(6);
    on_mask = 8'h00;
    win(4);
    chk(16'(zone_fire), 16'h1);
    chk(16'(fire_vote_a), 16'h0);
    on_mask = 8'h12;
    win(6);
    chk(16'({zone_fire, surv_alarm}), 16'h31);
    on_mask = 8'h00;
    win(4);
    chk(16'({zone_fire, surv_alarm, fire_vote_a}), 16'h061);
    keylock_reset = 1'b1;
    step(5);
    keylock_reset = 1'b0;
    chk(16'({zone_fire, fire_vote_a}), 16'h0);
    on_mask = 8'h01;
    win(6);
    on_mask = 8'h00;
    win(4);
    chk(16'(zone_fire), 16'h1);
    ext_inhibit = 1'b1;
    step(5);
    ext_inhibit = 1'b0;
    chk(16'(zone_fire), 16'h0);
    // Longest delay: 33 windows, judged with a margin either side
    sw.nonlatch_closed = 1'b1;
    sw.delay_closed = 5'h1F;
    on_mask = 8'h0F;
    win(25);
    chk(16'(zone_fire), 16'h0);
    win(12);
    chk(16'(zone_fire), 16'hF);
    on_mask = 8'h00;
    // Mid-run reset drops every output while zones are still in fire
    rst_n = 1'b0;
    step(1);
    chk(16'({zone_fire, fire_vote_a, fire_vote_b, low_alarm}), 16'h0);
    tally_and_finish();
  end
  initial begin
    #1500000;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
